/* verilog/sid_core.sv */
`timescale 1ns/10ps
// Notes on behaviour
// RULE_01: Literal form computes immediate minus accumulator.
// RULE_02: Literal form writes only the accumulator.
// RULE_03: File form computes addressed register minus accumulator.
// RULE_04: Target bit zero writes accumulator only.
// RULE_05: Target bit one writes register only.
// RULE_06: Carry set means no borrow occurred.
// RULE_07: Both update carry, nibble flag, zero; one cycle.
`include "sid_defs.svh"
module sid_core
(
   // Clock and reset.
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   // Instruction issue, one instruction per cycle while valid is high.
   input wire logic instr_valid_in,
   input wire sid_pkg::sid_word_t instr_in,
   // File register read data for the address on reg_raddr_out, same cycle.
   input wire sid_pkg::sid_byte_t reg_rdata_in,
   // File register read address, combinational from the instruction.
   output sid_pkg::sid_addr_t reg_raddr_out,
   // File register write port, registered.
   output logic reg_we_out,
   output sid_pkg::sid_addr_t reg_waddr_out,
   output sid_pkg::sid_byte_t reg_wdata_out,
   // Accumulator and flags.
   output sid_pkg::sid_byte_t acc_out,
   output logic carry_out,
   output logic nibble_borrow_flag_out,
   output logic zero_out
);
   import sid_pkg::*;

   // ******************************************************
   // State.
   // ******************************************************

   // All registered state of the slice.
   typedef struct packed
   {
      sid_byte_t acc;
      logic carry;
      logic nib;
      logic zero;
      logic we;
      sid_addr_t waddr;
      sid_byte_t wdata;
   } sid_state_s;

   sid_state_s state_ff; // Registered state.
   sid_state_s nxt_state; // Next value of the state.
   sid_op_e op; // Decoded operation.
   sid_byte_t minuend; // Left operand of the subtraction.
   sid_byte_t diff; // Difference.
   logic no_borrow; // Carry out of the full subtraction.
   logic nib_no_borrow; // Carry out of the low nibble.

   // Decoding of the opcode field, used by the datapath and the checks.
   function automatic sid_op_e decode_op(input sid_word_t w);
      begin
         if ((w & `SID_LIT_OP_MASK) == `SID_LIT_OP_VAL)
         begin
            decode_op = SID_OP_LIT;
         end
         else if ((w & `SID_REG_OP_MASK) == `SID_REG_OP_VAL)
         begin
            decode_op = SID_OP_REG;
         end
         else
         begin
            decode_op = SID_OP_NONE;
         end
      end
   endfunction

   // ******************************************************
   // Datapath.
   // ******************************************************

   // Operand choice: immediate for the literal form, file data otherwise.
   always_comb
   begin
      op = instr_valid_in ? decode_op(instr_in) : SID_OP_NONE;
      if (op == SID_OP_LIT)
      begin
         minuend = instr_in[`SID_IMM_MSB:0]; // RULE_01
      end
      else
      begin
         minuend = reg_rdata_in; // RULE_03
      end
   end

   // Shared subtractor; the accumulator is always the subtrahend.
   sid_sub8 u_sub
   (
      .minuend_in(minuend),
      .subtrahend_in(state_ff.acc),
      .diff_out(diff),
      .no_borrow_out(no_borrow),
      .nib_no_borrow_out(nib_no_borrow)
   );

   // Next state: the write target and flags follow the decoded form.
   always_comb
   begin
      nxt_state = state_ff;
      nxt_state.we = 1'b0;
      case (op)
         SID_OP_LIT:
         begin
            nxt_state.acc = diff; // RULE_02
         end
         SID_OP_REG:
         begin
            if (instr_in[`SID_DEST_BIT])
            begin
               nxt_state.we = 1'b1; // RULE_05
               nxt_state.waddr = instr_in[`SID_ADDR_MSB:0];
               nxt_state.wdata = diff;
            end
            else
            begin
               nxt_state.acc = diff; // RULE_04
            end
         end
         default:
         begin
            nxt_state.we = 1'b0;
         end
      endcase
      // Flags are updated by both forms in the same cycle.
      if (op != SID_OP_NONE)
      begin
         nxt_state.carry = no_borrow; // RULE_06
         nxt_state.nib = nib_no_borrow; // RULE_07
         nxt_state.zero = (diff == 8'h00); // RULE_07
      end
   end

   // State register.
   always_ff @(posedge clk_sys_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         state_ff <= '0;
         state_ff.acc <= `SID_ACC_RST;
         state_ff.carry <= `SID_FLAG_RST;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // ******************************************************
   // Outputs.
   // ******************************************************

   // Read address is taken straight from the instruction word so data returns this cycle.
   assign reg_raddr_out = instr_in[`SID_ADDR_MSB:0];
   assign reg_we_out = state_ff.we;
   assign reg_waddr_out = state_ff.waddr;
   assign reg_wdata_out = state_ff.wdata;
   assign acc_out = state_ff.acc;
   assign carry_out = state_ff.carry;
   assign nibble_borrow_flag_out = state_ff.nib;
   assign zero_out = state_ff.zero;

   // ******************************************************
   // Checks.
   // ******************************************************

   // Literal form result lands in the accumulator one edge later.
   lit_result_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RULE_01
      (instr_valid_in && decode_op(instr_in) == SID_OP_LIT)
      |=> acc_out == 8'($past(instr_in[7:0]) - $past(acc_out)))
      else $error("literal difference wrong");

   // Literal form never writes a file register.
   lit_nowrite_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RULE_02
      (instr_valid_in && decode_op(instr_in) == SID_OP_LIT) |=> !reg_we_out)
      else $error("literal form wrote a register");

   // File form to accumulator keeps the register untouched.
   reg_to_acc_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RULE_04
      (instr_valid_in && decode_op(instr_in) == SID_OP_REG && !instr_in[7])
      |=> !reg_we_out && acc_out == 8'($past(reg_rdata_in) - $past(acc_out)))
      else $error("file form to accumulator wrong");

   // File form to register writes the difference and keeps the accumulator.
   reg_to_reg_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RULE_05
      (instr_valid_in && decode_op(instr_in) == SID_OP_REG && instr_in[7])
      |=> reg_we_out && $stable(acc_out) && reg_waddr_out == $past(instr_in[6:0])
          && reg_wdata_out == 8'($past(reg_rdata_in) - $past(acc_out)))
      else $error("file form to register wrong"); // RULE_03

   // Carry means the minuend was not below the accumulator.
   carry_flag_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RULE_06
      (instr_valid_in && decode_op(instr_in) == SID_OP_LIT)
      |=> carry_out == ($past(instr_in[7:0]) >= $past(acc_out)))
      else $error("carry flag wrong");

   // Zero flag follows the accumulator result.
   zero_flag_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RULE_07
      (instr_valid_in && (decode_op(instr_in) == SID_OP_LIT
          || (decode_op(instr_in) == SID_OP_REG && !instr_in[7])))
      |=> zero_out == (acc_out == 8'h00))
      else $error("zero flag wrong");

   // File form to register takes its zero flag from the written byte.
   reg_zero_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RULE_07
      (instr_valid_in && decode_op(instr_in) == SID_OP_REG && instr_in[7])
      |=> zero_out == (reg_wdata_out == 8'h00))
      else $error("file form zero flag wrong");

   // File form carry and nibble flags compare the register byte with the accumulator.
   reg_flags_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RULE_06
      (instr_valid_in && decode_op(instr_in) == SID_OP_REG)
      |=> carry_out == ($past(reg_rdata_in) >= $past(acc_out))
          && nibble_borrow_flag_out == ($past(reg_rdata_in[3:0]) >= $past(acc_out[3:0])))
      else $error("file form flags wrong");

   // Nibble flag means the low nibble did not borrow.
   nib_flag_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RULE_07
      (instr_valid_in && decode_op(instr_in) == SID_OP_LIT)
      |=> nibble_borrow_flag_out == ($past(instr_in[3:0]) >= $past(acc_out[3:0])))
      else $error("nibble flag wrong");

   // Non-subtract words change nothing.
   idle_hold_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // RULE_07
      (!instr_valid_in || decode_op(instr_in) == SID_OP_NONE)
      |=> !reg_we_out && $stable(acc_out) && $stable(carry_out) && $stable(zero_out))
      else $error("idle cycle changed state");
endmodule

/* verilog/sid_defs.svh */
`ifndef SID_DEFS_SVH
`define SID_DEFS_SVH

// Opcode pattern of the literal form: bits 13..9 are 5'b11110, bit 8 is ignored.
`define SID_LIT_OP_MASK 14'h3E00
`define SID_LIT_OP_VAL 14'h3C00
// Opcode pattern of the file form: bits 13..8 are 6'b000010.
`define SID_REG_OP_MASK 14'h3F00
`define SID_REG_OP_VAL 14'h0200
// Field positions inside the instruction word.
`define SID_DEST_BIT 7
`define SID_ADDR_MSB 6
`define SID_IMM_MSB 7
// Reset values.
`define SID_ACC_RST 8'h00
`define SID_FLAG_RST 1'b0

`endif

/* verilog/sid_pkg.sv */
package sid_pkg;
   // Instruction word and data types.
   typedef logic [13:0] sid_word_t;
   typedef logic [7:0] sid_byte_t;
   typedef logic [6:0] sid_addr_t;
   // Decoded operation kind.
   typedef enum logic [1:0] {SID_OP_NONE, SID_OP_LIT, SID_OP_REG} sid_op_e;
endpackage

/* verilog/sid_sub8.sv */
`timescale 1ns/10ps
// Eight-bit subtractor: minuend minus subtrahend by adding the complement plus one.
module sid_sub8
(
   // Operands.
   input wire logic [7:0] minuend_in,
   input wire logic [7:0] subtrahend_in,
   // Results.
   output logic [7:0] diff_out,
   output logic no_borrow_out,
   output logic nib_no_borrow_out
);
   // Full-width and low-nibble sums with carry out.
   logic [8:0] full_sum;
   logic [4:0] nib_sum;

   // Carry out of a complement-add is set when no borrow occurred.
   always_comb
   begin
      full_sum = {1'b0, minuend_in} + {1'b0, ~subtrahend_in} + 9'h001;
      nib_sum = {1'b0, minuend_in[3:0]} + {1'b0, ~subtrahend_in[3:0]} + 5'h01;
      diff_out = full_sum[7:0];
      no_borrow_out = full_sum[8];
      nib_no_borrow_out = nib_sum[4];
   end
endmodule

/* sim/subtract_instruction_datapath_tb.sv */
`timescale 1ns/10ps
// ****************************************************************
// Bench for the subtract datapath: drives words, checks each result.
// ****************************************************************
module subtract_instruction_datapath_tb;
   import sid_pkg::*;
   logic clk_sys_in;
   logic arst_n_in;
   logic instr_valid_in;
   sid_word_t instr_in;
   sid_byte_t reg_rdata_in;
   sid_addr_t reg_raddr_out;
   logic reg_we_out;
   sid_addr_t reg_waddr_out;
   sid_byte_t reg_wdata_out;
   sid_byte_t acc_out;
   logic carry_out;
   logic nibble_borrow_flag_out;
   logic zero_out;
   // Expected accumulator and flags, kept by the bench itself.
   sid_byte_t e_acc;
   logic e_c;
   logic e_dc;
   logic e_z;
   int fails;
   int n_checks;
   sid_core i_dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
      .instr_valid_in(instr_valid_in), .instr_in(instr_in), .reg_rdata_in(reg_rdata_in),
      .reg_raddr_out(reg_raddr_out), .reg_we_out(reg_we_out), .reg_waddr_out(reg_waddr_out),
      .reg_wdata_out(reg_wdata_out), .acc_out(acc_out), .carry_out(carry_out),
      .nibble_borrow_flag_out(nibble_borrow_flag_out), .zero_out(zero_out));
   // Free-running 25 MHz clock.
   initial
   begin
      clk_sys_in = 1'b0;
      forever #20 clk_sys_in = ~clk_sys_in;
   end
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Counts one comparison and reports it when it does not hold.
   task automatic chk(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1)
      begin
         fails++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   // Issues one word (valid stays high, so calls run back to back) and judges the result.
   task automatic exec(input sid_word_t w, input sid_byte_t rd);
      logic lit;
      logic fil;
      sid_byte_t m;
      sid_byte_t d;
      lit = (w[13:9] == 5'b11110);
      fil = (w[13:8] == 6'b000010);
      m = lit ? w[7:0] : rd;
      d = m - e_acc;
      instr_valid_in = 1'b1;
      instr_in = w;
      reg_rdata_in = rd;
      #1 chk(reg_raddr_out === w[6:0], "read index");
      @(posedge clk_sys_in);
      #1;
      if (lit || fil)
      begin
         e_c = (m >= e_acc);
         e_dc = (m[3:0] >= e_acc[3:0]);
         e_z = (d == 8'h00);
      end
      if (lit || (fil && !w[7]))
         e_acc = d;
      chk(acc_out === e_acc && carry_out === e_c, "difference or carry");
      chk(nibble_borrow_flag_out === e_dc && zero_out === e_z, "nibble or zero");
      chk(reg_we_out === (fil && w[7]), "write strobe");
      if (fil && w[7])
         chk(reg_waddr_out === w[6:0] && reg_wdata_out === d, "write port");
   endtask
   // Drops valid for one cycle while a subtract word stands on the bus.
   task automatic idle();
      instr_valid_in = 1'b0;
      instr_in = 14'h3C_55;
      @(posedge clk_sys_in);
      #1 chk(acc_out === e_acc && reg_we_out === 1'b0, "idle changed state");
      chk(carry_out === e_c && zero_out === e_z, "idle changed flags");
      chk(nibble_borrow_flag_out === e_dc, "idle changed nibble flag");
   endtask
   // Pulses reset in mid-run and checks that every registered output clears.
   task automatic t_reset();
      instr_valid_in = 1'b0;
      arst_n_in = 1'b0;
      #1 chk(acc_out === 8'h00 && carry_out === 1'b0 && zero_out === 1'b0, "reset flags");
      chk(nibble_borrow_flag_out === 1'b0 && reg_we_out === 1'b0, "reset nibble");
      chk(reg_waddr_out === 7'h00 && reg_wdata_out === 8'h00, "reset write port");
      @(posedge clk_sys_in);
      #1 arst_n_in = 1'b1;
      e_acc = 8'h00;
      e_c = 1'b0;
      e_dc = 1'b0;
      e_z = 1'b0;
   endtask
   // Literal form over boundary immediates, both settings of the ignored bit.
   task automatic t_lit();
      sid_byte_t k[6] = '{8'h02, 8'h03, 8'h02, 8'h00, 8'hFF, 8'h10};
      for (int i = 0; i < 6; i++)
         exec({5'b11110, i[0], k[i]}, 8'hA5);
      idle();
   endtask
   // File form to both targets, index boundaries, borrow and zero cases.
   task automatic t_file();
      exec(14'h02_FF, 8'h03);
      exec(14'h02_80, 8'h0F);
      exec(14'h02_00, 8'h00);
      exec(14'h02_7F, 8'hF0);
      exec(14'h02_85, 8'hF0);
      exec(14'h3C_20, 8'h00);
      idle();
   endtask
   // Words of other instructions leave all state alone.
   task automatic t_refuse();
      exec(14'h0D_85, 8'h55);
      exec(14'h03_85, 8'h55);
      exec(14'h3A_12, 8'h55);
      idle();
   endtask
   // Watchdog: the tests need well under 100 cycles.
   initial
   begin
      #(40 * 2000);
      fails++;
      stop_test();
   end
   // Main sequence: reset for five cycles, then the scenarios.
   initial
   begin
      fails = 0;
      n_checks = 0;
      e_acc = 8'h00;
      e_c = 1'b0;
      e_dc = 1'b0;
      e_z = 1'b0;
      arst_n_in = 1'b0;
      instr_valid_in = 1'b0;
      instr_in = 14'h00_00;
      reg_rdata_in = 8'h00;
      repeat (5) @(posedge clk_sys_in);
      #1 arst_n_in = 1'b1;
      chk(acc_out === 8'h00 && carry_out === 1'b0 && reg_we_out === 1'b0, "reset");
      chk(zero_out === 1'b0 && nibble_borrow_flag_out === 1'b0, "reset flags");
      t_lit();
      t_file();
      t_reset();
      t_refuse();
      stop_test();
   end
endmodule
